// file: hdl/tcr_edge_sync.sv
`timescale 1ns/1ns

module tcr_edge_sync
    import tcr_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // raw pins
    input tcr_pins_t i_pins,
    // one-cycle falling edge pulses
    output tcr_pins_t o_fall
);

    typedef struct packed {
        tcr_pins_t meta;
        tcr_pins_t sync;
        tcr_pins_t prev;
        tcr_pins_t fall;
    } tcr_sync_state_t;

    tcr_sync_state_t sync_ff;
    tcr_sync_state_t nxt_sync;

    // pins idle high, so reset to ones to avoid a false edge after reset
    always_comb
    begin
        nxt_sync = sync_ff;
        nxt_sync.meta = i_pins;
        nxt_sync.sync = sync_ff.meta;
        nxt_sync.prev = sync_ff.sync;
        nxt_sync.fall = sync_ff.prev & ~sync_ff.sync;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            sync_ff <= '{meta: '1, sync: '1, prev: '1, fall: '0};
        end
        else
        begin
            sync_ff <= nxt_sync;
        end
    end

    assign o_fall = sync_ff.fall;

endmodule // tcr_edge_sync

// file: hdl/tcr_pkg.sv
package tcr_pkg;

    // register byte offsets on the avalon slave
    localparam logic [4:0] TCR_OFS_CTRL = 5'h00;
    localparam logic [4:0] TCR_OFS_CKCTL = 5'h04;
    localparam logic [4:0] TCR_OFS_CNT_LO = 5'h08;
    localparam logic [4:0] TCR_OFS_CNT_HI = 5'h0c;
    localparam logic [4:0] TCR_OFS_RCAP_LO = 5'h10;
    localparam logic [4:0] TCR_OFS_RCAP_HI = 5'h14;
    localparam logic [4:0] TCR_OFS_AUX = 5'h18;

    // field positions
    localparam int TCR_CKCTL_DIV1_BIT = 5;
    localparam int TCR_AUX_ADC_BIT = 0;

    // values after reset
    localparam logic [7:0] TCR_CTRL_RST = 8'h00;
    localparam logic [15:0] TCR_CNT_RST = 16'h0000;
    localparam logic [15:0] TCR_RCAP_RST = 16'h0000;

    // cycle counts
    localparam logic [3:0] TCR_DIV12_LAST = 4'hb;
    localparam logic [3:0] TCR_DIV2_LAST = 4'h1;
    localparam logic [3:0] TCR_BIT_PRE_LAST = 4'hf;
    localparam logic [15:0] TCR_CNT_MAX = 16'hffff;

    typedef struct packed {
        logic overflow_flag;
        logic ext_edge_flag;
        logic rx_baud_select;
        logic tx_baud_select;
        logic ext_enable;
        logic run_control;
        logic counter_select;
        logic capture_reload_select;
    } tcr_ctrl_t;

    typedef struct packed {
        logic ext_count_pin;
        logic ext_trigger_pin;
    } tcr_pins_t;

    typedef enum logic [1:0] {
        TCR_MODE_OFF,
        TCR_MODE_CAPTURE,
        TCR_MODE_RELOAD,
        TCR_MODE_BAUD
    } tcr_mode_t;

    typedef struct packed {
        tcr_ctrl_t ctrl;
        logic clock_divide_select;
        logic adc_start_enable;
        logic [15:0] count;
        logic [15:0] rcap;
        logic [3:0] pre_cnt;
        logic ext_half;
        logic [3:0] rx_pre;
        logic [3:0] tx_pre;
        logic rx_shift;
        logic tx_shift;
        logic rx_bit;
        logic tx_bit;
        logic adc_start;
        logic irq;
        logic waitreq;
        logic [31:0] rdata;
    } tcr_state_t;

    localparam tcr_state_t TCR_STATE_RST = '{
        ctrl: TCR_CTRL_RST,
        count: TCR_CNT_RST,
        rcap: TCR_RCAP_RST,
        waitreq: 1'b1,
        default: '0
    };

endpackage

// file: hdl/tcr_timer2.sv
`timescale 1ns/1ns

// Overview of operation
// - count register is 16 bits, read and written as low and high bytes
// - timer function counts system clock divided by one or twelve, by two in baud mode
// - counter function increments on each falling edge of count pin, on every second edge in baud mode
// - overflow can be selected as an adc conversion start pulse
// - run off means off; else baud bits, then capture/reload bit pick mode
// - capture mode: enabled trigger edge copies count into reload pair
// - with external enable clear, trigger edges are ignored entirely
// - capture and reload modes: rollover sets overflow flag, requests interrupt
// - reload mode: overflow loads reload pair into the count
// - reload mode: enabled trigger edge also reloads the count
// - run bit starts the timer; clearing it stops every mode
// - either baud select forces reload behaviour regardless of capture bit
// - baud mode: overflow sets no flag, gives a uart shift clock pulse
// - overflow goes to rx clock and tx clock by their own selects
// - baud shift clocks only when the uart runs in mode 1 or 3
// - uart bit rate is the overflow rate divided by sixteen
// - baud timebase is system clock over two, or the count pin
// - external baud rate is pin frequency over 32 times reload distance
// - baud mode: enabled trigger edge sets external flag, requests interrupt
module tcr_timer2
    import tcr_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // avalon-mm slave
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // external pins
    input wire logic i_ext_count_pin,
    input wire logic i_ext_trigger_pin,
    // uart side
    input wire logic i_uart_mode_1_or_3,
    output logic o_rx_shift_clk,
    output logic o_tx_shift_clk,
    output logic o_rx_bit_tick,
    output logic o_tx_bit_tick,
    // system side
    output logic o_timer_irq,
    output logic o_adc_start
);

    tcr_state_t st_ff;
    tcr_state_t nxt_st;
    tcr_pins_t pins;
    tcr_pins_t fall;
    tcr_mode_t mode;
    logic baud_sel;
    logic sys_tick;
    logic ext_tick;
    logic inc;
    logic ovf;
    logic trig;
    logic bus_req;
    logic bus_take;
    logic bus_wr;
    logic lane0;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    assign pins.ext_count_pin = i_ext_count_pin;
    assign pins.ext_trigger_pin = i_ext_trigger_pin;

    tcr_edge_sync u_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_pins(pins),
        .o_fall(fall)
    );

    // mode decode
    always_comb
    begin
        baud_sel = st_ff.ctrl.rx_baud_select | st_ff.ctrl.tx_baud_select;
        if (!st_ff.ctrl.run_control)
        begin
            mode = TCR_MODE_OFF;
        end
        else if (baud_sel)
        begin
            mode = TCR_MODE_BAUD;
        end
        else if (st_ff.ctrl.capture_reload_select)
        begin
            mode = TCR_MODE_CAPTURE;
        end
        else
        begin
            mode = TCR_MODE_RELOAD;
        end
    end

    // count source: prescaled system clock or count pin edges
    always_comb
    begin
        if (mode == TCR_MODE_BAUD)
        begin
            sys_tick = (st_ff.pre_cnt == TCR_DIV2_LAST);
        end
        else if (st_ff.clock_divide_select)
        begin
            sys_tick = 1'b1;
        end
        else
        begin
            sys_tick = (st_ff.pre_cnt == TCR_DIV12_LAST);
        end
        // every second pin edge in baud mode gives the 32 of the rate formula
        if (mode == TCR_MODE_BAUD)
        begin
            ext_tick = fall.ext_count_pin & st_ff.ext_half;
        end
        else
        begin
            ext_tick = fall.ext_count_pin;
        end
        if (mode == TCR_MODE_OFF)
        begin
            inc = 1'b0;
        end
        else if (st_ff.ctrl.counter_select)
        begin
            inc = ext_tick;
        end
        else
        begin
            inc = sys_tick;
        end
        ovf = inc & (st_ff.count == TCR_CNT_MAX);
        trig = fall.ext_trigger_pin & st_ff.ctrl.ext_enable & (mode != TCR_MODE_OFF);
    end

    // bus decode
    always_comb
    begin
        bus_req = i_avs_read | i_avs_write;
        bus_take = bus_req & st_ff.waitreq;
        bus_wr = i_avs_write & ~st_ff.waitreq;
        lane0 = i_avs_byteenable[0];
        wbyte = i_avs_writedata[7:0];
        case (i_avs_address)
            TCR_OFS_CTRL:
            begin
                rbyte = st_ff.ctrl;
            end
            TCR_OFS_CKCTL:
            begin
                rbyte = 8'h00;
                rbyte[TCR_CKCTL_DIV1_BIT] = st_ff.clock_divide_select;
            end
            TCR_OFS_CNT_LO:
            begin
                rbyte = st_ff.count[7:0];
            end
            TCR_OFS_CNT_HI:
            begin
                rbyte = st_ff.count[15:8];
            end
            TCR_OFS_RCAP_LO:
            begin
                rbyte = st_ff.rcap[7:0];
            end
            TCR_OFS_RCAP_HI:
            begin
                rbyte = st_ff.rcap[15:8];
            end
            TCR_OFS_AUX:
            begin
                rbyte = 8'h00;
                rbyte[TCR_AUX_ADC_BIT] = st_ff.adc_start_enable;
            end
            default:
            begin
                rbyte = 8'h00;
            end
        endcase
    end

    always_comb
    begin
        nxt_st = st_ff;

        // prescalers restart whenever the timer is stopped
        if (mode == TCR_MODE_OFF)
        begin
            nxt_st.pre_cnt = 4'h0;
            nxt_st.ext_half = 1'b0;
        end
        else
        begin
            if (sys_tick)
            begin
                nxt_st.pre_cnt = 4'h0;
            end
            else
            begin
                nxt_st.pre_cnt = st_ff.pre_cnt + 4'h1;
            end
            if (fall.ext_count_pin && mode == TCR_MODE_BAUD)
            begin
                nxt_st.ext_half = ~st_ff.ext_half;
            end
        end

        // count and reload/capture pair
        if (inc)
        begin
            nxt_st.count = st_ff.count + 16'h0001;
        end
        if (ovf && (mode == TCR_MODE_RELOAD || mode == TCR_MODE_BAUD))
        begin
            nxt_st.count = st_ff.rcap;
        end
        if (trig && mode == TCR_MODE_RELOAD)
        begin
            nxt_st.count = st_ff.rcap;
        end
        if (trig && mode == TCR_MODE_CAPTURE)
        begin
            nxt_st.rcap = st_ff.count;
        end

        // baud outputs: per-overflow shift clocks and divided-by-16 bit ticks
        nxt_st.rx_shift = ovf & (mode == TCR_MODE_BAUD) & st_ff.ctrl.rx_baud_select
            & i_uart_mode_1_or_3;
        nxt_st.tx_shift = ovf & (mode == TCR_MODE_BAUD) & st_ff.ctrl.tx_baud_select
            & i_uart_mode_1_or_3;
        nxt_st.rx_bit = 1'b0;
        nxt_st.tx_bit = 1'b0;
        if (nxt_st.rx_shift)
        begin
            nxt_st.rx_pre = st_ff.rx_pre + 4'h1;
            nxt_st.rx_bit = (st_ff.rx_pre == TCR_BIT_PRE_LAST);
        end
        if (nxt_st.tx_shift)
        begin
            nxt_st.tx_pre = st_ff.tx_pre + 4'h1;
            nxt_st.tx_bit = (st_ff.tx_pre == TCR_BIT_PRE_LAST);
        end
        if (mode != TCR_MODE_BAUD)
        begin
            nxt_st.rx_pre = 4'h0;
            nxt_st.tx_pre = 4'h0;
        end

        nxt_st.adc_start = ovf & st_ff.adc_start_enable;

        // bus handshake: one wait cycle, then the access completes
        nxt_st.waitreq = 1'b1;
        if (bus_take)
        begin
            nxt_st.waitreq = 1'b0;
            nxt_st.rdata = {24'h000000, rbyte};
        end

        // software writes; a byte write to the count wins over counting
        if (bus_wr && lane0)
        begin
            case (i_avs_address)
                TCR_OFS_CTRL:
                begin
                    nxt_st.ctrl = wbyte;
                end
                TCR_OFS_CKCTL:
                begin
                    nxt_st.clock_divide_select = wbyte[TCR_CKCTL_DIV1_BIT];
                end
                TCR_OFS_CNT_LO:
                begin
                    nxt_st.count[7:0] = wbyte;
                end
                TCR_OFS_CNT_HI:
                begin
                    nxt_st.count[15:8] = wbyte;
                end
                TCR_OFS_RCAP_LO:
                begin
                    if (!(trig && mode == TCR_MODE_CAPTURE))
                    begin
                        nxt_st.rcap[7:0] = wbyte;
                    end
                end
                TCR_OFS_RCAP_HI:
                begin
                    if (!(trig && mode == TCR_MODE_CAPTURE))
                    begin
                        nxt_st.rcap[15:8] = wbyte;
                    end
                end
                TCR_OFS_AUX:
                begin
                    nxt_st.adc_start_enable = wbyte[TCR_AUX_ADC_BIT];
                end
                default:
                begin
                    nxt_st.adc_start_enable = st_ff.adc_start_enable;
                end
            endcase
        end

        // hardware sets win over a software clear in the same cycle
        if (ovf && mode != TCR_MODE_BAUD)
        begin
            nxt_st.ctrl.overflow_flag = 1'b1;
        end
        if (trig)
        begin
            nxt_st.ctrl.ext_edge_flag = 1'b1;
        end

        // the interrupt enable lives in the system interrupt controller
        nxt_st.irq = nxt_st.ctrl.overflow_flag | nxt_st.ctrl.ext_edge_flag;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            st_ff <= TCR_STATE_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_avs_readdata = st_ff.rdata;
    assign o_avs_waitrequest = st_ff.waitreq;
    assign o_rx_shift_clk = st_ff.rx_shift;
    assign o_tx_shift_clk = st_ff.tx_shift;
    assign o_rx_bit_tick = st_ff.rx_bit;
    assign o_tx_bit_tick = st_ff.tx_bit;
    assign o_timer_irq = st_ff.irq;
    assign o_adc_start = st_ff.adc_start;

endmodule // tcr_timer2

// file: tb/tcr_pin_src.sv
`timescale 1ns/1ns

module tcr_pin_src (
    // clock and requests
    input wire logic i_clk,
    input wire logic i_cnt_go,
    input wire logic i_trg_go,
    // pins toward the timer
    output logic o_ext_count_pin,
    output logic o_ext_trigger_pin
);
    logic [2:0] cnt_ff = 3'h0;
    logic [2:0] trg_ff = 3'h0;
    // idle high; low phase of four cycles so the synchroniser cannot miss it
    always_ff @(posedge i_clk)
    begin
        cnt_ff <= i_cnt_go ? 3'h4 : cnt_ff - {2'h0, cnt_ff != 3'h0};
        trg_ff <= i_trg_go ? 3'h4 : trg_ff - {2'h0, trg_ff != 3'h0};
    end
    assign o_ext_count_pin = (cnt_ff == 3'h0);
    assign o_ext_trigger_pin = (trg_ff == 3'h0);
endmodule // tcr_pin_src

// file: tb/tcr_timer2_bench.sv
`timescale 1ns/1ns

module tcr_timer2_bench
    import tcr_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'h1;
    logic um = 1'b1;
    logic cgo = 1'b0;
    logic tgo = 1'b0;
    logic [7:0] rv;
    logic [7:0] exq[$];
    int fails = 0;
    int checks = 0;
    logic cpin, tpin, wreq, rxs, txs, rxt, txt, irq, adc;
    logic [31:0] rdata;
    logic [4:0] pv;
    int npulse = 0;
    int n0;
    assign pv = {txt, adc, rxs, txs, rxt};

    always #5 clk = ~clk;

    tcr_pin_src u_tcr_pin_src (
        .i_clk(clk),
        .i_cnt_go(cgo),
        .i_trg_go(tgo),
        .o_ext_count_pin(cpin),
        .o_ext_trigger_pin(tpin)
    );

    tcr_timer2 u_tcr_timer2 (
        .i_clk(clk),
        .i_resetn(rstn),
        .i_avs_address(adr),
        .i_avs_read(rd),
        .i_avs_write(wr),
        .i_avs_writedata(wd),
        .i_avs_byteenable(be),
        .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq),
        .i_ext_count_pin(cpin),
        .i_ext_trigger_pin(tpin),
        .i_uart_mode_1_or_3(um),
        .o_rx_shift_clk(rxs),
        .o_tx_shift_clk(txs),
        .o_rx_bit_tick(rxt),
        .o_tx_bit_tick(txt),
        .o_timer_irq(irq),
        .o_adc_start(adc)
    );

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // request held until waitrequest is seen low, released only at that edge
    // no cycle limit here: only the watchdog may end a wait for the answer
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic b0);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= {8'($urandom), 16'h0, d};
        be <= {3'($urandom), b0};
        do
        begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic put(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask

    task automatic rdx(input logic [4:0] a, input logic [7:0] e);
        exq.push_back(e);
        bus(1'b0, a, 8'h00, 1'b1);
    endtask

    task automatic pin(input logic k);
        @(posedge clk);
        cgo <= !k;
        tgo <= k;
        @(posedge clk);
        cgo <= 1'b0;
        tgo <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // cycles between two consecutive pulses of one output
    task automatic gap(input int i, input int e);
        int n;
        n = 0;
        while (pv[i] !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pv[i] !== 1'b1 && n < 3000);
        chk("pulse gap", 16'(e), 16'(n));
    endtask

    always @(posedge clk)
    begin
        if (rd && wreq === 1'b0)
            chk("read data", {8'h00, exq.pop_front()}, rdata[15:0]);
    end

    // shift pulses seen so far, for the uart mode gating check
    always @(posedge clk)
    begin
        if (rxs === 1'b1 || txs === 1'b1)
            npulse <= npulse + 1;
    end

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #500000;
        fails++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(58));
        rv = 8'($urandom);
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rdx(TCR_OFS_CTRL, TCR_CTRL_RST);
        rdx(TCR_OFS_CNT_HI, 8'h00);
        rdx(5'h1c, 8'h00);
        put(TCR_OFS_CNT_LO, rv);
        put(TCR_OFS_RCAP_HI, ~rv);
        rdx(TCR_OFS_CNT_LO, rv);
        rdx(TCR_OFS_RCAP_HI, ~rv);
        bus(1'b1, TCR_OFS_CNT_LO, ~rv, 1'b0);
        rdx(TCR_OFS_CNT_LO, rv);
        $display("done registers");
        put(TCR_OFS_CNT_LO, 8'h00);
        put(TCR_OFS_CTRL, 8'h0f);
        repeat (5) pin(1'b0);
        pin(1'b1);
        repeat (3) pin(1'b0);
        rdx(TCR_OFS_CNT_LO, 8'h08);
        rdx(TCR_OFS_RCAP_LO, 8'h05);
        rdx(TCR_OFS_RCAP_HI, 8'h00);
        rdx(TCR_OFS_CTRL, 8'h4f);
        put(TCR_OFS_CTRL, 8'h07);
        pin(1'b1);
        rdx(TCR_OFS_RCAP_LO, 8'h05);
        rdx(TCR_OFS_CTRL, 8'h07);
        put(TCR_OFS_CNT_HI, 8'hff);
        put(TCR_OFS_CNT_LO, 8'hff);
        pin(1'b0);
        rdx(TCR_OFS_CNT_HI, 8'h00);
        rdx(TCR_OFS_CTRL, 8'h87);
        chk("interrupt", 16'h0001, 16'(irq));
        put(TCR_OFS_CTRL, 8'h03);
        pin(1'b0);
        rdx(TCR_OFS_CNT_LO, 8'h00);
        chk("interrupt", 16'h0000, 16'(irq));
        $display("done capture");
        put(TCR_OFS_RCAP_LO, rv);
        put(TCR_OFS_RCAP_HI, 8'h12);
        put(TCR_OFS_CNT_HI, 8'hff);
        put(TCR_OFS_CNT_LO, 8'hff);
        put(TCR_OFS_CTRL, 8'h0e);
        pin(1'b0);
        rdx(TCR_OFS_CNT_LO, rv);
        rdx(TCR_OFS_CNT_HI, 8'h12);
        pin(1'b0);
        pin(1'b1);
        rdx(TCR_OFS_CNT_LO, rv);
        rdx(TCR_OFS_CTRL, 8'hce);
        $display("done reload");
        put(TCR_OFS_RCAP_LO, 8'hfc);
        put(TCR_OFS_RCAP_HI, 8'hff);
        put(TCR_OFS_CNT_HI, 8'hff);
        put(TCR_OFS_CTRL, 8'h35);
        gap(2, 8);
        gap(1, 8);
        gap(0, 128);
        gap(4, 128);
        rdx(TCR_OFS_CTRL, 8'h35);
        put(TCR_OFS_CNT_LO, 8'hfc);
        put(TCR_OFS_CTRL, 8'h16);
        fork
            repeat (20) pin(1'b0);
            gap(1, 80);
        join
        put(TCR_OFS_CTRL, 8'h3c);
        pin(1'b1);
        rdx(TCR_OFS_CTRL, 8'h7c);
        um <= 1'b0;
        // a pulse launched with the old mode level may still be in flight
        repeat (2) @(posedge clk);
        n0 = npulse;
        repeat (48) @(posedge clk);
        chk("gated shift pulses", 16'h0000, 16'(npulse - n0));
        um <= 1'b1;
        gap(1, 8);
        $display("done baud");
        put(TCR_OFS_CTRL, 8'h00);
        put(TCR_OFS_AUX, 8'h01);
        put(TCR_OFS_CKCTL, 8'h00);
        put(TCR_OFS_RCAP_LO, 8'hfe);
        put(TCR_OFS_CNT_LO, 8'hfe);
        put(TCR_OFS_CTRL, 8'h04);
        gap(3, 24);
        put(TCR_OFS_CKCTL, 8'h20);
        gap(3, 2);
        put(TCR_OFS_CTRL, 8'h00);
        repeat (30) @(posedge clk);
        $display("done timebase");
        give_verdict();
    end
endmodule // tcr_timer2_bench

// file: tb/tcr_timer2_monitor.sv
`timescale 1ns/1ns

module tcr_timer2_monitor
    import tcr_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // bus
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_write,
    input wire logic i_avs_read,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // pins and events
    input wire logic i_ext_trigger_pin,
    input wire logic i_uart_mode_1_or_3,
    input wire logic o_rx_shift_clk,
    input wire logic o_tx_shift_clk,
    input wire logic o_timer_irq,
    input wire logic o_adc_start
);
    logic [7:0] ctl_ff;
    logic wr0;
    // mode bits are only ever changed by software, so a shadow is exact
    assign wr0 = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
        && i_avs_address == TCR_OFS_CTRL;
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            ctl_ff <= 8'h00;
        else if (wr0)
            ctl_ff <= i_avs_writedata[7:0];
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_taken;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_trig;
        $fell(i_ext_trigger_pin) && ctl_ff[3] && ctl_ff[2];
    endsequence
    AST_WREQ_ONE: assert property (s_taken |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer not after exactly one wait cycle");
    AST_RD_UPPER: assert property (i_avs_read && !o_avs_waitrequest |->
        o_avs_readdata[31:8] == 24'h0) else $error("read data upper bits not zero");
    AST_RX_SRC: assert property (o_rx_shift_clk |-> $past(ctl_ff[5]) && $past(ctl_ff[2])
        && $past(i_uart_mode_1_or_3)) else $error("rx shift pulse without rx select");
    AST_TX_SRC: assert property (o_tx_shift_clk |-> $past(ctl_ff[4]) && $past(ctl_ff[2])
        && $past(i_uart_mode_1_or_3)) else $error("tx shift pulse without tx select");
    AST_ADC_RUN: assert property (o_adc_start |-> $past(ctl_ff[2]))
        else $error("adc start while stopped");
    AST_TX_GAP: assert property (o_tx_shift_clk |=> !o_tx_shift_clk)
        else $error("baud overflows closer than two cycles");
    AST_IRQ_FALL: assert property ($fell(o_timer_irq) |-> $past(wr0))
        else $error("interrupt dropped without software clear");
    AST_TRIG_FLAG: assert property (s_trig |-> ##[1:6] o_timer_irq)
        else $error("trigger edge raised no interrupt");
endmodule // tcr_timer2_monitor

bind tcr_timer2 tcr_timer2_monitor u_tcr_timer2_monitor (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_avs_address(i_avs_address),
    .i_avs_write(i_avs_write),
    .i_avs_read(i_avs_read),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_ext_trigger_pin(i_ext_trigger_pin),
    .i_uart_mode_1_or_3(i_uart_mode_1_or_3),
    .o_rx_shift_clk(o_rx_shift_clk),
    .o_tx_shift_clk(o_tx_shift_clk),
    .o_timer_irq(o_timer_irq),
    .o_adc_start(o_adc_start)
);
